// *** common/mac_cfg_pkg.sv ***
package mac_cfg_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] CFG1_OFF = 16'h9200;
  localparam logic [15:0] CFG2_OFF = 16'h9210;
  localparam logic [15:0] IPGT_OFF = 16'h9220;
  localparam logic [15:0] IPGR_OFF = 16'h9230;
  localparam logic [15:0] CLRT_OFF = 16'h9240;
  localparam logic [15:0] MAXF_OFF = 16'h9250;
  localparam int NUM_REGS = 6;
  localparam logic [15:0] REG_STRIDE = 16'h0010;
  // alias offsets within a register slot
  localparam logic [3:0] ALIAS_PLAIN = 4'h0;
  localparam logic [3:0] ALIAS_CLR = 4'h4;
  localparam logic [3:0] ALIAS_SET = 4'h8;
  localparam logic [3:0] ALIAS_INV = 4'hc;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] CFG1_RST = 16'h800d;
  localparam logic [15:0] CFG2_RST = 16'h4082;
  localparam logic [15:0] IPGT_RST = 16'h0012;
  localparam logic [15:0] IPGR_RST = 16'h0c12;
  localparam logic [15:0] CLRT_RST = 16'h370f;
  localparam logic [15:0] MAXF_RST = 16'h05ee;
  localparam int MAX_FRAME_OCTETS = 1518;
  // ****************************************
  // first configuration register fields
  // ****************************************
  localparam int MAC_BLOCK_RESET_BIT = 15;
  localparam int BACKOFF_RNG_RESET_BIT = 14;
  localparam int RX_CTRL_RESET_BIT = 11;
  localparam int RX_FUNC_RESET_BIT = 10;
  localparam int TX_CTRL_RESET_BIT = 9;
  localparam int TX_FUNC_RESET_BIT = 8;
  localparam int LOOPBACK_BIT = 4;
  localparam int PAUSE_TX_BIT = 3;
  localparam int PAUSE_RX_BIT = 2;
  localparam int ACCEPT_ALL_BIT = 1;
  localparam int RECEIVE_ON_BIT = 0;
  // writable bits of the first configuration register
  localparam logic [15:0] CFG1_MASK = 16'hcf1f;
  // ****************************************
  // ahb constants
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic mac_block_reset_ctl;
    logic backoff_rng_reset;
    logic rx_ctrl_sublayer_reset;
    logic rx_function_reset;
    logic tx_ctrl_sublayer_reset;
    logic tx_function_reset;
    logic loopback;
    logic pause_tx_permit;
    logic pause_rx_honor;
    logic accept_all_frames;
    logic receive_on;
  } mac_ctl_s;

  typedef struct packed {
    logic [15:0] cfg_two;
    logic [15:0] b2b_gap;
    logic [15:0] nb2b_gap;
    logic [15:0] coll_retry;
    logic [15:0] max_frame_len_field;
  } mac_param_s;
endpackage

// *** hw/mac_config_control.sv ***
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] block reset bit holds mac and media core in reset; reads one
// [R02] backoff rng reset bit resets transmit backoff random generator
// [R03] rx control sublayer reset bit holds that logic in reset
// [R04] rx function reset bit holds receive function in reset
// [R05] tx control sublayer reset bit holds that logic in reset
// [R06] tx function reset bit holds transmit function in reset
// [R07] loopback bit routes transmit interface into receive interface
// [R08] pause transmit bit permits pause frames, zero blocks them
// [R09] pause receive bit makes mac honour received pause frames
// [R10] accept-all bit passes control frames, zero drops them
// [R11] receive-on bit enables frame reception
// [R12] only 16 and 32 bit accesses act; 8 bit accesses ignored; here only 8 bit writes are ignored, 8 bit reads still return the register
// [R13] clear, set, invert aliases at plus 0x4, 0x8, 0xc
// [R14] reset loads 800d, 0c12, 05ee and other documented defaults
// [R15] upper half-words read zero and ignore writes
// [R16] default max frame length equals 1518 octets
// [R17] reset bits are levels, held until software clears them
module mac_config_control #(
  parameter logic [15:0] BASE_ADDR = 16'h9200
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output mac_cfg_pkg::mac_ctl_s ctl,
  output mac_cfg_pkg::mac_param_s params,
  output logic mac_core_reset,
  output logic rx_ctrl_reset,
  output logic rx_func_reset,
  output logic tx_ctrl_reset,
  output logic tx_func_reset,
  output logic backoff_rng_clear,
  // transmit path to media, receive path from media
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  input wire logic [7:0] media_rx_data,
  input wire logic media_rx_valid,
  input wire logic rx_is_control,
  input wire logic rx_is_pause,
  input wire logic tx_is_pause,
  output logic [7:0] media_tx_data,
  output logic media_tx_valid,
  output logic tx_pause_blocked,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic pause_honored
);
  // ****************************************
  // elaboration checks
  // ****************************************
  // slots are 16 bytes apart, so the base must sit on a slot boundary
  if (BASE_ADDR[3:0] != 4'h0) begin : g_bad_base
    $error("base address must be aligned to 16 bytes");
  end

  // the slot index is three bits wide
  if (mac_cfg_pkg::NUM_REGS > 8) begin : g_bad_count
    $error("at most eight register slots");
  end

  // ****************************************
  // helpers
  // ****************************************
  // byte-lane write mask; 8-bit sizes give no lanes at all
  function automatic logic [15:0] lane_mask(input logic [2:0] sz,
                                            input logic a1);
    lane_mask = 16'h0000;
    if (sz == mac_cfg_pkg::HSIZE_WORD) begin
      lane_mask = 16'hffff;
    end else if (sz == mac_cfg_pkg::HSIZE_HALF && !a1) begin
      lane_mask = 16'hffff;
    end
  endfunction

  function automatic logic [15:0] apply_alias(input logic [15:0] cur,
                                              input logic [15:0] wd,
                                              input logic [3:0] op,
                                              input logic [15:0] m);
    logic [15:0] r;
    r = cur;
    case (op)
      mac_cfg_pkg::ALIAS_PLAIN: r = (cur & ~m) | (wd & m);
      mac_cfg_pkg::ALIAS_CLR: r = cur & ~(wd & m);
      mac_cfg_pkg::ALIAS_SET: r = cur | (wd & m);
      mac_cfg_pkg::ALIAS_INV: r = cur ^ (wd & m);
      default: r = cur;
    endcase
    apply_alias = r;
  endfunction

  // value that software sees after reset, slot by slot [R14]
  function automatic logic [15:0] reset_value(input int idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      0: v = mac_cfg_pkg::CFG1_RST; // [R01] [R14]
      1: v = mac_cfg_pkg::CFG2_RST;
      2: v = mac_cfg_pkg::IPGT_RST;
      3: v = mac_cfg_pkg::IPGR_RST; // [R14]
      4: v = mac_cfg_pkg::CLRT_RST;
      5: v = mac_cfg_pkg::MAXF_RST; // [R14] [R16]
      default: v = 16'h0000;
    endcase
    reset_value = v;
  endfunction

  // slot decode shared by the read and the write side
  function automatic logic slot_ok(input logic [15:0] rel);
    slot_ok = (rel[15:7] == 9'h000) &&
              (rel[6:4] < 3'(mac_cfg_pkg::NUM_REGS));
  endfunction

  // only the first register has unimplemented bits in its low half
  function automatic logic [15:0] slot_mask(input int idx);
    slot_mask = 16'hffff;
    if (idx == 0) begin
      slot_mask = mac_cfg_pkg::CFG1_MASK;
    end
  endfunction

  // ****************************************
  // ahb address phase capture
  // ****************************************
  logic pend_wr;
  logic pend_valid;
  logic [15:0] pend_addr;
  logic [2:0] pend_size;
  logic [15:0] rel_addr;
  logic [2:0] reg_idx;
  logic idx_ok;
  logic [3:0] alias_op;
  logic [15:0] wmask;
  logic [15:0] regs [mac_cfg_pkg::NUM_REGS];
  logic [15:0] next_val [mac_cfg_pkg::NUM_REGS];
  logic [mac_cfg_pkg::NUM_REGS-1:0] wr_hit;
  logic [15:0] addr_rel;
  logic accept;

  assign accept = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_valid <= 1'b0;
    end else begin
      pend_valid <= accept;
    end
  end

  // address phase kept for the data phase that follows it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_wr <= 1'b0;
      pend_addr <= 16'h0000;
      pend_size <= mac_cfg_pkg::HSIZE_WORD;
    end else begin
      if (accept) begin
        pend_wr <= hwrite;
        pend_addr <= haddr[15:0];
        pend_size <= hsize;
      end
    end
  end

  assign rel_addr = pend_addr - BASE_ADDR;
  assign reg_idx = rel_addr[6:4];
  assign idx_ok = slot_ok(rel_addr);
  assign alias_op = {rel_addr[3:2], 2'h0};
  // upper half-word lanes never reach storage [R15]
  assign wmask = lane_mask(pend_size, rel_addr[1]); // [R12]

  // ****************************************
  // register storage
  // ****************************************
  for (genvar g = 0; g < mac_cfg_pkg::NUM_REGS; g++) begin : g_slot
    assign next_val[g] = apply_alias(regs[g], hwdata[15:0], alias_op,
                                     wmask) & slot_mask(g); // [R13]
    assign wr_hit[g] = pend_valid && pend_wr && idx_ok &&
                       (reg_idx == 3'(g));

    always_ff @(posedge sys_clk) begin
      if (rst) begin
        regs[g] <= reset_value(g);
      end else if (wr_hit[g]) begin
        // bits stay until software writes them back [R17]
        regs[g] <= next_val[g];
      end
    end
  end

  // ****************************************
  // read data
  // ****************************************
  assign addr_rel = haddr[15:0] - BASE_ADDR;

  // latched at the address phase, stands through the data phase;
  // a write landing on the same edge is passed straight through
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (accept && !hwrite) begin
      hrdata <= 32'h00000000;
      if (slot_ok(addr_rel)) begin
        if (wr_hit[addr_rel[6:4]]) begin
          hrdata <= {16'h0000, next_val[addr_rel[6:4]]}; // [R15]
        end else begin
          hrdata <= {16'h0000, regs[addr_rel[6:4]]}; // [R15]
        end
      end
    end
  end

  // ****************************************
  // control fan-out
  // ****************************************
  always_comb begin
    ctl.mac_block_reset_ctl = regs[0][mac_cfg_pkg::MAC_BLOCK_RESET_BIT];
    ctl.backoff_rng_reset = regs[0][mac_cfg_pkg::BACKOFF_RNG_RESET_BIT];
    ctl.rx_ctrl_sublayer_reset = regs[0][mac_cfg_pkg::RX_CTRL_RESET_BIT];
    ctl.rx_function_reset = regs[0][mac_cfg_pkg::RX_FUNC_RESET_BIT];
    ctl.tx_ctrl_sublayer_reset = regs[0][mac_cfg_pkg::TX_CTRL_RESET_BIT];
    ctl.tx_function_reset = regs[0][mac_cfg_pkg::TX_FUNC_RESET_BIT];
    ctl.loopback = regs[0][mac_cfg_pkg::LOOPBACK_BIT];
    ctl.pause_tx_permit = regs[0][mac_cfg_pkg::PAUSE_TX_BIT];
    ctl.pause_rx_honor = regs[0][mac_cfg_pkg::PAUSE_RX_BIT];
    ctl.accept_all_frames = regs[0][mac_cfg_pkg::ACCEPT_ALL_BIT];
    ctl.receive_on = regs[0][mac_cfg_pkg::RECEIVE_ON_BIT];
    params.cfg_two = regs[1];
    params.b2b_gap = regs[2];
    params.nb2b_gap = regs[3];
    params.coll_retry = regs[4];
    params.max_frame_len_field = regs[5];
  end

  // block reset dominates every sub-reset
  assign mac_core_reset = ctl.mac_block_reset_ctl; // [R01]
  assign rx_ctrl_reset = ctl.mac_block_reset_ctl |
                         ctl.rx_ctrl_sublayer_reset; // [R03]
  assign rx_func_reset = ctl.mac_block_reset_ctl |
                         ctl.rx_function_reset; // [R04]
  assign tx_ctrl_reset = ctl.mac_block_reset_ctl |
                         ctl.tx_ctrl_sublayer_reset; // [R05]
  assign tx_func_reset = ctl.mac_block_reset_ctl |
                         ctl.tx_function_reset; // [R06]
  assign backoff_rng_clear = ctl.mac_block_reset_ctl |
                             ctl.backoff_rng_reset; // [R02]

  // ****************************************
  // datapath steering
  // ****************************************
  logic tx_ok;
  logic [7:0] rx_src_data;
  logic rx_src_valid;
  logic rx_ok;

  assign tx_ok = tx_valid_in && !tx_func_reset && !tx_ctrl_reset &&
                 !(tx_is_pause && !ctl.pause_tx_permit); // [R08]
  assign tx_pause_blocked = tx_valid_in && tx_is_pause &&
                            !ctl.pause_tx_permit; // [R08]
  // loopback takes transmit bytes in place of the media [R07]
  assign rx_src_data = ctl.loopback ? tx_data_in : media_rx_data;
  assign rx_src_valid = ctl.loopback ? tx_ok : media_rx_valid;
  assign rx_ok = rx_src_valid && ctl.receive_on && !rx_func_reset &&
                 (ctl.accept_all_frames || !rx_is_control); // [R11] [R10]

  always_ff @(posedge sys_clk) begin
    if (rst || tx_func_reset) begin
      media_tx_valid <= 1'b0;
    end else begin
      // no media output while looped back [R07]
      media_tx_valid <= tx_ok && !ctl.loopback;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || tx_func_reset) begin
      media_tx_data <= 8'h00;
    end else begin
      media_tx_data <= tx_data_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || rx_func_reset) begin
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= rx_ok; // [R11]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || rx_func_reset) begin
      rx_data_out <= 8'h00;
    end else begin
      rx_data_out <= rx_src_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || rx_ctrl_reset) begin
      pause_honored <= 1'b0;
    end else begin
      pause_honored <= rx_src_valid && rx_is_pause &&
                       ctl.pause_rx_honor && ctl.receive_on; // [R09]
    end
  end
endmodule

// *** tb/mac_cfg_monitor.sv ***
`timescale 1ns/1ps
// ********
// port checks
// ********
module mac_cfg_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire mac_cfg_pkg::mac_ctl_s ctl,
  input wire mac_cfg_pkg::mac_param_s params,
  input wire logic mac_core_reset,
  input wire logic rx_ctrl_reset,
  input wire logic rx_func_reset,
  input wire logic tx_ctrl_reset,
  input wire logic tx_func_reset,
  input wire logic backoff_rng_clear,
  input wire logic tx_pause_blocked,
  input wire logic rx_valid_out,
  input wire logic pause_honored
);
  logic take;
  logic rd_ph;
  logic wr_ph;
  logic wr_byte;
  assign take = hsel && hready && htrans[1];
  // data phases; a write lands on the edge closing its data phase
  always_ff @(posedge sys_clk) begin
    rd_ph <= !rst && take && !hwrite;
    wr_ph <= !rst && take && hwrite;
    wr_byte <= !rst && take && hwrite && hsize == 3'h0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_CORE_RESET: assert property (
    mac_core_reset == ctl.mac_block_reset_ctl)
    else $error("core reset off block bit");
  AST_RNG_RESET: assert property (
    backoff_rng_clear == (ctl.backoff_rng_reset | ctl.mac_block_reset_ctl))
    else $error("rng clear wrong");
  AST_SUB_RESETS: assert property (
    {rx_ctrl_reset, rx_func_reset,
    tx_ctrl_reset, tx_func_reset} == ({ctl.rx_ctrl_sublayer_reset,
    ctl.rx_function_reset, ctl.tx_ctrl_sublayer_reset,
    ctl.tx_function_reset} | {4{ctl.mac_block_reset_ctl}}))
    else $error("sub reset level wrong");
  // runs through reset on purpose: the values right after it matter
  AST_RESET_VALUE: assert property (disable iff (1'b0) rst |=>
    ctl.mac_block_reset_ctl && params.max_frame_len_field == 16'h05ee &&
    params.nb2b_gap == 16'h0c12) else $error("reset value wrong");
  AST_LEVEL_HOLD: assert property (ctl.mac_block_reset_ctl && !wr_ph |=>
    ctl.mac_block_reset_ctl) else $error("block reset cleared itself");
  AST_BYTE_IGNORED: assert property (
    wr_byte |=> $stable(ctl) && $stable(params))
    else $error("byte write acted");
  AST_UPPER_ZERO: assert property (rd_ph |-> hrdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  AST_PAUSE_TX: assert property (
    tx_pause_blocked |-> !ctl.pause_tx_permit)
    else $error("pause blocked while permitted");
  AST_RX_OFF: assert property (!ctl.receive_on |=> !rx_valid_out)
    else $error("receive while off");
  AST_PAUSE_RX: assert property (!ctl.pause_rx_honor |=> !pause_honored)
    else $error("pause acted while ignored");
  cover property (wr_byte);
  cover property (tx_pause_blocked);
  cover property (pause_honored);
endmodule

bind mac_config_control mac_cfg_monitor i_mac_cfg_monitor (.sys_clk, .rst,
  .hsel, .htrans, .hwrite, .hsize, .hready, .hrdata, .ctl, .params,
  .mac_core_reset, .rx_ctrl_reset, .rx_func_reset, .tx_ctrl_reset,
  .tx_func_reset, .backoff_rng_clear, .tx_pause_blocked, .rx_valid_out,
  .pause_honored);

// *** tb/sw_bus_master.sv ***
`timescale 1ns/1ps
// ********
// software side master
// ********
module sw_bus_master (
  input wire logic sys_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h0,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h0
);
  // byte size only when the bench wants it refused
  task automatic xfer(input logic wr, input logic [31:0] a,
      input logic [2:0] sz, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= mac_cfg_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
    // released data must not look like the last value
    hwdata <= ~wd;
  endtask
endmodule

// *** tb/test_mac_config_control.sv ***
`timescale 1ns/1ps
// ********
// bench
// ********
module test_mac_config_control;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp, media_tx_valid, tx_pause_blocked;
  logic rx_valid_out, pause_honored, mac_core_reset, rx_ctrl_reset;
  logic rx_func_reset, tx_ctrl_reset, tx_func_reset, backoff_rng_clear;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] media_tx_data, rx_data_out;
  logic [7:0] tx_data_in = 8'h00;
  logic [7:0] media_rx_data = 8'h00;
  logic tx_valid_in = 1'b0, tx_is_pause = 1'b0, media_rx_valid = 1'b0;
  logic rx_is_control = 1'b0, rx_is_pause = 1'b0;
  mac_cfg_pkg::mac_ctl_s ctl;
  mac_cfg_pkg::mac_param_s params;
  int error_cnt = 0;
  int cmp_count = 0;

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  sw_bus_master i_sw_bus_master (.sys_clk, .hready(hreadyout), .hrdata,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  mac_config_control i_mac_config_control (.sys_clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .ctl, .params, .mac_core_reset, .rx_ctrl_reset,
    .rx_func_reset, .tx_ctrl_reset, .tx_func_reset, .backoff_rng_clear,
    .tx_data_in, .tx_valid_in, .media_rx_data, .media_rx_valid,
    .rx_is_control, .rx_is_pause, .tx_is_pause, .media_tx_data,
    .media_tx_valid, .tx_pause_blocked, .rx_data_out, .rx_valid_out,
    .pause_honored);

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_sw_bus_master.xfer(1'b0, {16'h0000, a}, 3'h2, 32'h0, d);
    chk($sformatf("reg %h", a), d, exp);
  endtask

  task automatic wr(input logic [15:0] a, input logic [2:0] s,
      input logic [31:0] d);
    logic [31:0] unused;
    i_sw_bus_master.xfer(1'b1, {16'h0000, a}, s, d, unused);
  endtask

  // flags: tx valid, tx pause, rx valid, rx control, rx pause
  task automatic drive(input logic [7:0] d, input logic [4:0] f);
    @(posedge sys_clk);
    tx_data_in <= d;
    media_rx_data <= d;
    {tx_valid_in, tx_is_pause, media_rx_valid, rx_is_control,
      rx_is_pause} <= f;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset();
    logic [15:0] rv [6] = '{16'h800d, 16'h4082, 16'h0012, 16'h0c12,
      16'h370f, 16'h05ee};
    for (int i = 0; i < 6; i++) begin
      rchk(16'h9200 + 16'(i * 16), {16'h0000, rv[i]});
    end
    rchk(16'h9260, 32'h0);
    repeat (20) @(posedge sys_clk);
    chk("core reset", mac_core_reset, 32'h1);
    chk("max frame", params.max_frame_len_field, 32'd1518);
    $display("test reset done");
  endtask

  // write address with its alias offset, size, data, expected readback of that slot
  task automatic t_writes();
    logic [15:0] ad [10] = '{16'h9200, 16'h9204, 16'h9208, 16'h920c,
      16'h9200, 16'h9258, 16'h925c, 16'h9250, 16'h9250, 16'h925c};
    logic [2:0] sz [10] = '{3'h2, 3'h1, 3'h2, 3'h2, 3'h0, 3'h1, 3'h2,
      3'h1, 3'h2, 3'h0};
    logic [31:0] wd [10] = '{32'hffffffff, 32'hcf00, 32'h0800, 32'h0011,
      32'h0, 32'h0001, 32'hffffffff, 32'h1234, 32'habcd05ee, 32'hffff};
    logic [15:0] ex [10] = '{16'hcf1f, 16'h001f, 16'h081f, 16'h080e,
      16'h080e, 16'h05ef, 16'hfa10, 16'h1234, 16'h05ee, 16'h05ee};
    for (int i = 0; i < 10; i++) begin
      wr(ad[i], sz[i], wd[i]);
      rchk(ad[i] & 16'hfff0, {16'h0000, ex[i]});
    end
    $display("test writes done");
  endtask

  task automatic t_path();
    wr(16'h9200, 3'h2, 32'h0013);
    drive(8'h5a, 5'b10000);
    chk("loop valid", rx_valid_out, 32'h1);
    chk("loop data", rx_data_out, 32'h5a);
    wr(16'h9200, 3'h2, 32'h0001);
    drive(8'h3c, 5'b11111);
    chk("pause blocked", tx_pause_blocked, 32'h1);
    chk("tx valid", media_tx_valid, 32'h0);
    chk("rx valid", rx_valid_out, 32'h0);
    chk("pause acted", pause_honored, 32'h0);
    wr(16'h9200, 3'h2, 32'h000f);
    drive(8'hc3, 5'b11111);
    chk("tx valid", media_tx_valid, 32'h1);
    chk("tx data", media_tx_data, 32'hc3);
    chk("rx valid", rx_valid_out, 32'h1);
    chk("pause acted", pause_honored, 32'h1);
    wr(16'h9200, 3'h2, 32'h010e);
    drive(8'h96, 5'b10100);
    chk("tx reset", tx_func_reset, 32'h1);
    chk("tx valid", media_tx_valid, 32'h0);
    chk("rx valid", rx_valid_out, 32'h0);
    chk("rng clear", backoff_rng_clear, 32'h0);
    drive(8'h00, 5'b00000);
    $display("test path done");
  endtask

  // rng reset bit, bus answer, then a reset in mid-run
  task automatic t_rerun();
    wr(16'h9208, 3'h2, 32'h4000);
    #1;
    chk("rng clear", backoff_rng_clear, 32'h1);
    chk("resp", {hresp, hreadyout}, 32'h1);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(16'h9200, 32'h800d);
    rchk(16'h9250, 32'h05ee);
    $display("test rerun done");
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_writes();
    t_path();
    t_rerun();
    report_and_stop();
  end

  // over a hundred times the roughly 150 cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
